// [hw/i2c_byte_master.sv]
// Top: two-wire byte transfer master with beeper and keypad sequences
// Notes on behaviour
// - A request word carries the slave address in its upper byte and register or data below.
// - A register write also takes a separate data byte, sent after the register number.
// - All transfers run on the bus clock line and bus data line.
// - A successful transfer returns a result whose upper byte is zero.
// - A failed transfer returns a result whose upper byte is all ones.
// - A read places the received byte in the low eight bits of the result.
// - The beeper writes DFh to expander 46h, waits briefly, then writes FFh.
// - Expander bit 5 is held low only for a short delay.
// - Keypad init writes BFh then FFh to the expander to pulse bit 6 low.
// - A keypad byte with bit 7 low carries valid key data in its low four bits.
// - Every key read that succeeds is followed by a repeat of the bit 6 init pulse.
`timescale 1ns/10ps
module i2c_byte_master
  import i2c_xfer_pkg::*;
#(
  parameter int BEEP_CYCLES = BEEP_CYC,
  parameter int QTR_CYCLES = QTR_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire i2c_xfer_pkg::op_t req_op,
  input wire logic [15:0] req_word,
  input wire logic [7:0] req_data,
  // Result
  output logic res_valid,
  output logic [15:0] res_word,
  output logic key_valid,
  output logic [3:0] key_code,
  // Bus lines
  input wire logic bus_clock_line_in,
  output logic bus_clock_line_oe,
  input wire logic bus_data_line_in,
  output logic bus_data_line_oe
);
  initial if (BEEP_CYCLES < 1) $error("BEEP_CYCLES must be at least 1");
  initial if (QTR_CYCLES < 2 || QTR_CYCLES > 65536) $error("QTR_CYCLES out of range");
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ADDR = 4'h1, S_B1 = 4'h2, S_B2 = 4'h3, S_RADDR = 4'h4,
    S_RBYTE = 4'h5, S_WAIT = 4'h6, S_DELAY = 4'h7, S_FIN = 4'h8
  } seq_t;
  byte_link_if lk ();
  logic [1:0] rst_sync_r;
  wire rst_sync_n = rst_sync_r[1];
  seq_t st_r, ret_r;
  op_t op_r;
  logic [6:0] addr_r;
  logic [7:0] b1_r, b2_r;
  logic fail_r;
  logic [1:0] pass_r;
  logic [31:0] dly_r;
  logic go_r, start_r, stop_r, rd_r;
  logic [7:0] wd_r;

  // Release goes through two flops so every state leaves reset on the same edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rst_sync_r <= 2'b00;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  wire is_seq = (req_op == OP_BEEP) || (req_op == OP_KEY_INIT) || (req_op == OP_KEY_READ);
  wire [6:0] req_addr = is_seq ? EXP_ADDR : req_word[15:9];
  wire [7:0] first_byte = (req_op == OP_BEEP) ? BEEP_ON :
                          is_seq ? LATCH_LOW : req_word[7:0];
  wire reads = (op_r == OP_REG_READ) || (op_r == OP_READ) || (op_r == OP_KEY_READ);
  wire [7:0] key_byte = lk.rdata;
  wire key_hit = ~key_byte[KEY_FLAG_BIT];
  // Only the first pass of a key read reads; its latch pulse passes are writes
  wire rd_first = (op_r == OP_READ) || (op_r == OP_KEY_READ && pass_r == 2'h0);
  // Passes that still owe the all-high write go through the delay first
  wire pulse_first = (pass_r == 2'h0) && (op_r == OP_BEEP || op_r == OP_KEY_INIT);
  wire pulse_next = !fail_r && (pulse_first || (pass_r == 2'h2 && op_r == OP_KEY_READ));
  assign req_ready = (st_r == S_IDLE);
  assign lk.go = go_r;
  assign lk.with_start = start_r;
  assign lk.with_stop = stop_r;
  assign lk.rd = rd_r;
  assign lk.nack_out = 1'b1;
  assign lk.wdata = wd_r;

  i2c_bit_engine #(.QTR(QTR_CYCLES)) u_eng (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .lk(lk),
    .scl_in(bus_clock_line_in),
    .scl_oe(bus_clock_line_oe),
    .sda_in(bus_data_line_in),
    .sda_oe(bus_data_line_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  task automatic issue(input logic s, input logic p, input logic r, input logic [7:0] d,
                       input seq_t nxt);
    go_r <= 1'b1; start_r <= s; stop_r <= p; rd_r <= r; wd_r <= d;
    ret_r <= nxt; st_r <= S_WAIT;
  endtask

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= S_IDLE; ret_r <= S_IDLE; op_r <= OP_WRITE; addr_r <= 7'h00;
      b1_r <= 8'h00; b2_r <= 8'h00; fail_r <= 1'b0; pass_r <= 2'h0; dly_r <= 32'h0;
      go_r <= 1'b0; start_r <= 1'b0; stop_r <= 1'b0; rd_r <= 1'b0; wd_r <= 8'h00;
      res_valid <= 1'b0; res_word <= 16'h0000; key_valid <= 1'b0; key_code <= 4'h0;
    end else begin
      go_r <= 1'b0;
      res_valid <= 1'b0;
      key_valid <= 1'b0;
      case (st_r)
        S_IDLE: if (req_valid) begin
          op_r <= req_op; addr_r <= req_addr; b1_r <= first_byte;
          b2_r <= req_data; fail_r <= 1'b0; pass_r <= 2'h0;
          st_r <= S_ADDR;
        end
        S_ADDR: begin
          if (rd_first) issue(1'b1, 1'b0, 1'b0, {addr_r, 1'b1}, S_RBYTE);
          else issue(1'b1, 1'b0, 1'b0, {addr_r, 1'b0}, S_B1);
        end
        S_B1: issue(1'b0, op_r != OP_REG_WRITE && op_r != OP_REG_READ, 1'b0, b1_r,
                    (op_r == OP_REG_WRITE) ? S_B2 : (op_r == OP_REG_READ) ? S_RADDR : S_FIN);
        S_B2: issue(1'b0, 1'b1, 1'b0, b2_r, S_FIN);
        S_RADDR: issue(1'b1, 1'b0, 1'b0, {addr_r, 1'b1}, S_RBYTE);
        S_RBYTE: issue(1'b0, 1'b1, 1'b1, 8'hff, S_FIN);
        S_WAIT: if (lk.done) begin
          // A read byte ends with a refused acknowledge on purpose, which is no failure
          if (!lk.acked && !(rd_r && stop_r)) begin
            fail_r <= 1'b1;
            st_r <= S_FIN;
          end else st_r <= ret_r;
        end
        S_DELAY: if (dly_r == 32'h0) begin
          b1_r <= ALL_HIGH; pass_r <= pass_r + 2'h1; st_r <= S_ADDR;
        end else dly_r <= dly_r - 32'h1;
        S_FIN: begin
          if (pulse_next) begin
            dly_r <= (op_r == OP_BEEP) ? 32'(BEEP_CYCLES - 1) : 32'h0;
            st_r <= S_DELAY;
          end else if (!fail_r && op_r == OP_KEY_READ && pass_r == 2'h0) begin
            key_valid <= key_hit;
            key_code <= key_byte[KEY_MSB:0];
            res_word <= {OK_BYTE, key_byte};
            b1_r <= LATCH_LOW; pass_r <= 2'h2; st_r <= S_ADDR;
          end else begin
            res_valid <= 1'b1;
            if (fail_r) res_word <= {FAIL_BYTE, res_word[7:0]};
            else if (op_r == OP_KEY_READ) res_word <= res_word;
            else res_word <= {OK_BYTE, reads ? lk.rdata : 8'h00};
            st_r <= S_IDLE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_fail_marks_ones: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_FIN && fail_r) |=> res_valid && res_word[15:8] == FAIL_BYTE)
    else $error("failure not marked in result");
  a_ok_marks_zero: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (res_valid && !$past(fail_r)) |-> res_word[15:8] == OK_BYTE)
    else $error("success result upper byte not zero");
  a_nack_ends_fail: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_WAIT && lk.done && !lk.acked && !rd_r) |=> fail_r && st_r == S_FIN)
    else $error("missing acknowledge not reported");
  a_read_low_byte: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_FIN && !fail_r && (op_r == OP_READ || op_r == OP_REG_READ))
    |=> res_word[7:0] == $past(lk.rdata))
    else $error("read byte not in low result bits");
  a_key_needs_flag: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    key_valid |-> !$past(key_byte[KEY_FLAG_BIT]))
    else $error("key reported with flag bit high");
  a_key_code_low: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    key_valid |-> key_code == $past(key_byte[KEY_MSB:0]))
    else $error("key code not the low four bits");
  a_key_then_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    key_valid |-> st_r == S_ADDR && b1_r == LATCH_LOW)
    else $error("key read not followed by latch pulse");
  a_key_clear_write: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_ADDR && op_r == OP_KEY_READ && pass_r == 2'h2)
    |=> !rd_r && lk.wdata == {EXP_ADDR, 1'b0})
    else $error("latch pulse after key read is not a write");
  a_key_pulse_delay: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_FIN && !fail_r && pass_r == 2'h2 && op_r == OP_KEY_READ) |=> st_r == S_DELAY)
    else $error("latch pulse after key read not completed");
  a_beep_delay_set: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_FIN && !fail_r && pass_r == 2'h0 && op_r == OP_BEEP)
    |=> st_r == S_DELAY && dly_r == 32'(BEEP_CYCLES - 1))
    else $error("beeper delay not loaded");
  a_second_high: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_DELAY && dly_r == 32'h0) |=> b1_r == ALL_HIGH && st_r == S_ADDR)
    else $error("second expander write not all high");
  a_seq_addr_fixed: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_IDLE && req_valid && is_seq) |=> addr_r == EXP_ADDR)
    else $error("sequence not aimed at the expander");
  a_req_addr_upper: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_IDLE && req_valid && !is_seq) |=> addr_r == $past(req_word[15:9]))
    else $error("slave address not taken from upper byte");
  a_reg_data_next: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_B1 && op_r == OP_REG_WRITE) |=> st_r == S_WAIT && ret_r == S_B2 && !stop_r)
    else $error("register write data byte not queued");
  a_first_low: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == S_IDLE && req_valid && req_op == OP_KEY_INIT) |=> b1_r == LATCH_LOW)
    else $error("keypad init first byte wrong");

  // Main scenarios
  c_beep: cover property (@(posedge clk_sys) res_valid && op_r == OP_BEEP);
  c_fail: cover property (@(posedge clk_sys) res_valid && res_word[15:8] == FAIL_BYTE);
  c_reg_read: cover property (@(posedge clk_sys) res_valid && op_r == OP_REG_READ);
  c_key: cover property (@(posedge clk_sys) key_valid);
  c_key_init: cover property (@(posedge clk_sys) res_valid && op_r == OP_KEY_INIT);
endmodule

// [hw/i2c_xfer_pkg.sv]
// Shared constants and types for the two-wire byte transfer master
package i2c_xfer_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SCL_HZ = 100_000;
  // Quarter bit period on the bus, in system clock cycles
  localparam int QTR_CYC = CLK_HZ / (SCL_HZ * 4);
  localparam int BEEP_US = 50_000;
  localparam int BEEP_CYC = (CLK_HZ / 1_000_000) * BEEP_US;
  localparam logic [6:0] EXP_ADDR = 7'h23;    // 46h as 8-bit write address
  localparam logic [7:0] BEEP_ON = 8'hdf;
  localparam logic [7:0] LATCH_LOW = 8'hbf;
  localparam logic [7:0] ALL_HIGH = 8'hff;
  localparam logic [7:0] OK_BYTE = 8'h00;
  localparam logic [7:0] FAIL_BYTE = 8'hff;
  localparam int KEY_FLAG_BIT = 7;
  localparam int KEY_MSB = 3;
  typedef enum logic [2:0] {
    OP_REG_WRITE = 3'h0,
    OP_REG_READ = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ = 3'h3,
    OP_BEEP = 3'h4,
    OP_KEY_INIT = 3'h5,
    OP_KEY_READ = 3'h6
  } op_t;
endpackage

// [hw/byte_link_if.sv]
// Byte level command path between sequencer and bit engine
`timescale 1ns/10ps
interface byte_link_if;
  import i2c_xfer_pkg::*;
  logic go;
  logic with_start;
  logic with_stop;
  logic rd;
  logic nack_out;
  logic [7:0] wdata;
  logic done;
  logic acked;
  logic [7:0] rdata;
  modport seq (output go, with_start, with_stop, rd, nack_out, wdata,
               input done, acked, rdata);
  modport eng (input go, with_start, with_stop, rd, nack_out, wdata,
               output done, acked, rdata);
endinterface

// [hw/i2c_bit_engine.sv]
// Bit level engine: optional start, one byte with acknowledge, optional stop
`timescale 1ns/10ps
module i2c_bit_engine
  import i2c_xfer_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  // Byte command
  byte_link_if.eng lk,
  // Bus lines (open drain: oe low means released)
  input wire logic scl_in,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_oe
);
  typedef enum logic [2:0] {
    E_IDLE = 3'h0, E_START = 3'h1, E_BIT = 3'h2, E_STOP = 3'h3, E_DONE = 3'h4
  } eng_t;
  eng_t st_r;
  logic [15:0] tick_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic stop_r, rd_r;
  logic [7:0] rx_r;
  logic ack_r;
  // The quarter counter is 16 bits wide, so slower bus rates need a wider counter
  initial if (QTR < 2 || QTR > 65536) $error("QTR must be 2 to 65536");
  wire tick = (tick_r == 16'(QTR - 1));
  wire in_ack = (bit_r == 4'h8);
  // Drive low when the shifted bit is zero; a read releases data on its eight bits and on ack sends nack_out
  wire tx_bit = sh_r[8];
  assign lk.done = (st_r == E_DONE);
  assign lk.acked = ack_r;
  assign lk.rdata = rx_r;
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= E_IDLE; tick_r <= 16'h0000; ph_r <= 2'h0; bit_r <= 4'h0;
      sh_r <= 9'h1ff; stop_r <= 1'b0; rd_r <= 1'b0; rx_r <= 8'h00;
      ack_r <= 1'b0; scl_oe <= 1'b0; sda_oe <= 1'b0;
    end else begin
      tick_r <= (tick || st_r == E_IDLE) ? 16'h0000 : tick_r + 16'h0001;
      case (st_r)
        E_IDLE: if (lk.go) begin
          stop_r <= lk.with_stop; rd_r <= lk.rd; ph_r <= 2'h0; bit_r <= 4'h0;
          sh_r <= lk.rd ? {8'hff, lk.nack_out} : {lk.wdata, 1'b1};
          st_r <= lk.with_start ? E_START : E_BIT;
        end
        E_START: if (tick) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) begin scl_oe <= 1'b0; sda_oe <= 1'b0; end
          if (ph_r == 2'h1) sda_oe <= 1'b1;
          if (ph_r == 2'h2) begin scl_oe <= 1'b1; st_r <= E_BIT; ph_r <= 2'h0; end
        end
        E_BIT: if (tick) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) sda_oe <= ~tx_bit;
          if (ph_r == 2'h1) scl_oe <= 1'b0;
          if (ph_r == 2'h2) begin
            if (in_ack) ack_r <= ~sda_in;
            else if (rd_r) rx_r <= {rx_r[6:0], sda_in};
          end
          if (ph_r == 2'h3) begin
            scl_oe <= 1'b1;
            sh_r <= {sh_r[7:0], 1'b1};
            bit_r <= bit_r + 4'h1;
            if (in_ack) begin
              st_r <= (stop_r || (!rd_r && sda_in)) ? E_STOP : E_DONE;
              ph_r <= 2'h0;
            end
          end
        end
        E_STOP: if (tick) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) sda_oe <= 1'b1;
          if (ph_r == 2'h1) scl_oe <= 1'b0;
          if (ph_r == 2'h2) begin sda_oe <= 1'b0; st_r <= E_DONE; end
        end
        E_DONE: st_r <= E_IDLE;
        default: st_r <= E_IDLE;
      endcase
    end
  end
  a_stop_sda_rise: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == E_STOP && ph_r == 2'h2 && tick) |=> !sda_oe && !scl_oe)
    else $error("stop did not release both lines");
  a_scl_hold_bit: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (st_r == E_BIT && $changed(sda_oe)) |-> scl_oe)
    else $error("data changed while clock high");
endmodule

// [test/expander_model.sv]
// Expander model: acks its own address, logs bytes, returns a set byte
`timescale 1ns/10ps
module expander_model #(
  parameter logic [6:0] ADDR = 7'h23
) (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  // Test control
  input wire logic [7:0] rd_byte,
  input wire logic ack_en
);
  logic [7:0] log_q[$];
  logic [7:0] sh = 8'h00;
  int cnt = 0;
  logic act = 1'b0;
  logic adr = 1'b0;
  logic rd = 1'b0;
  logic rd_nxt = 1'b0;
  logic hit;
  initial sda_oe = 1'b0;
  //////////////////////////////////////////////////////////////////
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    adr = 1'b1;
    rd = 1'b0;
    cnt = 0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;
  always @(posedge scl) if (act && cnt < 9) begin
    if (!rd && cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt++;
    end else if (rd) cnt++;
  end
  // Data only changes while the clock is low, so no false start or stop
  always @(negedge scl) if (act) begin
    if (cnt == 9) begin
      sda_oe = rd_nxt & ~rd_byte[7];
      rd = rd_nxt;
      rd_nxt = 1'b0;
      cnt = 0;
    end else if (rd) begin
      sda_oe = (cnt < 8) ? ~rd_byte[7 - cnt] : 1'b0;
    end else if (cnt == 8) begin
      log_q.push_back(sh);
      hit = !adr || sh[7:1] == ADDR;
      sda_oe = ack_en & hit;
      rd_nxt = adr & sh[0] & hit;
      adr = 1'b0;
      cnt = 9;
    end
  end
endmodule

// [test/i2c_byte_transfer_master_test.sv]
// Bench for the byte transfer master with an expander model on the bus
`timescale 1ns/10ps
module i2c_byte_transfer_master_test;
  import i2c_xfer_pkg::*;
  logic clk_sys, rst_n, req_valid, req_ready, res_valid, key_valid;
  op_t req_op;
  logic [15:0] req_word, res_word, r;
  logic [7:0] req_data, rd_byte;
  logic [3:0] key_code, key_cap;
  logic scl_oe, sda_oe, slv_oe, ack_en, key_seen;
  wire logic scl_w, sda_w;
  int err_count = 0;
  int comparisons = 0;
  // Open drain lines with pull-ups
  assign scl_w = ~scl_oe;
  assign sda_w = ~(sda_oe | slv_oe);
  // A short quarter bit keeps the run small; the bus protocol is the same
  i2c_byte_master #(.BEEP_CYCLES(20), .QTR_CYCLES(25)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_word(req_word),
    .req_data(req_data), .res_valid(res_valid), .res_word(res_word),
    .key_valid(key_valid), .key_code(key_code), .bus_clock_line_in(scl_w),
    .bus_clock_line_oe(scl_oe), .bus_data_line_in(sda_w), .bus_data_line_oe(sda_oe));
  expander_model expander (.scl(scl_w), .sda(sda_w), .sda_oe(slv_oe),
    .rd_byte(rd_byte), .ack_en(ack_en));
  //////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (key_valid === 1'b1) begin
    key_seen <= 1'b1;
    key_cap <= key_code;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    comparisons++;
    if (seen !== expv) begin
      err_count++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask
  task automatic check_log(input logic [7:0] e[$]);
    check(16'(expander.log_q.size()), 16'(e.size()), "byte count");
    foreach (e[i]) if (i < expander.log_q.size()) check({8'h00, expander.log_q[i]},
      {8'h00, e[i]}, "bus byte");
  endtask
  // Waits are bounded so a stuck handshake shows up as a mismatch
  task automatic run_req(input op_t op, input logic [15:0] word, input logic [7:0] data);
    int n;
    n = 0;
    expander.log_q.delete();
    key_seen = 1'b0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_op <= op;
    req_word <= word;
    req_data <= data;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    check(16'(n >= 100), 16'h0000, "request not taken");
    n = 0;
    @(negedge clk_sys);
    while (res_valid !== 1'b1 && n < 10000) begin
      @(negedge clk_sys);
      n++;
    end
    r = res_word;
    check(16'(n >= 10000), 16'h0000, "no result");
  endtask
  task automatic test_done;
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_reg_write;
    run_req(OP_REG_WRITE, 16'h4612, 8'h5c);
    check({r[15:8], 8'h00}, 16'h0000, "reg write status");
    check_log('{8'h46, 8'h12, 8'h5c});
  endtask
  task automatic t_beep;
    run_req(OP_BEEP, 16'h0000, 8'h00);
    check({r[15:8], 8'h00}, 16'h0000, "beep status");
    check_log('{8'h46, 8'hdf, 8'h46, 8'hff});
  endtask
  task automatic t_key_read;
    rd_byte = 8'h6a;
    run_req(OP_KEY_READ, 16'h4600, 8'h00);
    check(r, 16'h006a, "key result");
    check({15'h0, key_seen}, 16'h0001, "key flag");
    check({12'h0, key_cap}, 16'h000a, "key code");
    check_log('{8'h47, 8'h46, 8'hbf, 8'h46, 8'hff});
    rd_byte = 8'h85;
    run_req(OP_KEY_READ, 16'h4600, 8'h00);
    check(r, 16'h0085, "idle key result");
    check({15'h0, key_seen}, 16'h0000, "no key flag");
    check_log('{8'h47, 8'h46, 8'hbf, 8'h46, 8'hff});
    rd_byte = 8'hff;
  endtask
  task automatic t_reg_read;
    rd_byte = 8'h3c;
    run_req(OP_REG_READ, 16'h4607, 8'h00);
    check(r, 16'h003c, "reg read result");
    check_log('{8'h46, 8'h07, 8'h47});
    rd_byte = 8'hff;
  endtask
  task automatic t_write;
    run_req(OP_WRITE, 16'h4633, 8'h00);
    check(r, 16'h0000, "write result");
    check_log('{8'h46, 8'h33});
  endtask
  task automatic t_key_init;
    run_req(OP_KEY_INIT, 16'h0000, 8'h00);
    check(r, 16'h0000, "key init result");
    check_log('{8'h46, 8'hbf, 8'h46, 8'hff});
  endtask
  task automatic t_fail;
    run_req(OP_READ, 16'h4800, 8'h00);
    check({r[15:8], 8'h00}, 16'hff00, "fail status");
    check_log('{8'h49});
    check({14'h0, scl_oe, sda_oe}, 16'h0000, "released");
  endtask
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = OP_WRITE;
    req_word = 16'h0000;
    req_data = 8'h00;
    rd_byte = 8'hff;
    ack_en = 1'b1;
    key_seen = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({14'h0, scl_oe, sda_oe}, 16'h0000, "idle");
    t_reg_write();
    t_write();
    t_reg_read();
    t_key_init();
    t_beep();
    t_key_read();
    t_fail();
    test_done();
  end
  // Eight requests of some thirty bytes need about 30000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
endmodule
